// ### bench/spc_operand_model.sv
`default_nettype none
module spc_operand_model (
    input  wire logic [31:0] instr,
    input  wire logic        src2_read,
    output logic      [31:0] src1_value,
    output logic      [31:0] src2_value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] regs [32];
    initial regs = '{default: 32'h0};
    assign src1_value = regs[instr[19:15]];
    // Unread port shows inverted data
    assign src2_value = src2_read ? regs[instr[24:20]] : ~regs[instr[24:20]];
endmodule : spc_operand_model
`default_nettype wire

// ### bench/spc_properties.sv
`default_nettype none
module spc_checker
    import spc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        issue_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] src1_value,
    input wire logic [31:0] src2_value,
    input wire logic        src2_read,
    input wire logic        illegal,
    input wire logic [31:0] result,
    input wire logic        result_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_taken; issue_valid && !illegal; endsequence
    sequence s_refused; issue_valid && illegal; endsequence
    function automatic logic lanes_ok(input logic [31:0] r, input logic byte_form);
        logic ok;
        ok = byte_form || (r[15:8] == r[7:0] && r[31:24] == r[23:16]);
        for (int i = 0; i < 4; i++) ok &= (r[i*8 +: 8] == 8'h00 || r[i*8 +: 8] == 8'hff);
        return ok;
    endfunction : lanes_ok
    a_answer_once: assert property (s_taken |=> result_valid) else $error("no answer");
    a_refused_quiet: assert property (s_refused |=> !result_valid && $stable(result)) else $error("refused answered");
    a_idle_quiet: assert property (!issue_valid |=> !result_valid && $stable(result)) else $error("idle answer");
    a_lane_shape: assert property (result_valid |-> lanes_ok(result, $past(instr[12]))) else $error("lane shape");
    a_equal_byte: assert property (s_taken ##0 (instr[31:27] == 5'h00 && instr[14:12] == SPC_F3_BYTE_VEC)
        |=> result[7:0] == {8{$past(src1_value[7:0]) == $past(src2_value[7:0])}}) else $error("equal lane");
    a_imm_no_read: assert property (s_taken ##0 instr[13] |-> !src2_read) else $error("imm read");
    a_reg_read: assert property (s_taken ##0 !instr[13] |-> src2_read) else $error("reg not read");
    a_bad_encoding: assert property (issue_valid && (instr[6:0] != SPC_MAJOR_OPCODE || !instr[SPC_FLAG_POS]
        || instr[31:27] > SPC_FUNCT5_LAST) |-> illegal) else $error("bad encoding taken");
endmodule : spc_checker
bind spc_simd_packed_compare_unit spc_checker i_spc_checker (.core_clk(core_clk), .reset(reset),
    .issue_valid(issue_valid), .instr(instr), .src1_value(src1_value), .src2_value(src2_value),
    .src2_read(src2_read), .illegal(illegal), .result(result), .result_valid(result_valid));
`default_nettype wire

// ### bench/spc_simd_packed_compare_unit_tb.sv
`default_nettype none
module spc_simd_packed_compare_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import spc_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, issue_valid = 1'b0, src2_read, illegal, result_valid;
    logic [31:0] instr = 32'h0, src1_value, src2_value, result;
    logic [2:0] forms [6] = '{SPC_F3_HALF_VEC, SPC_F3_HALF_SC, SPC_F3_HALF_IMM,
                              SPC_F3_BYTE_VEC, SPC_F3_BYTE_SC, SPC_F3_BYTE_IMM};
    logic [31:0] flips [6] = '{32'h1, 32'h0400_0000, 32'h5000_0000, 32'h2000, 32'h3000, 32'h0200_0000};
    int bad_count = 0, n_compared = 0;
    always #50 core_clk = ~core_clk;
    spc_simd_packed_compare_unit i_spc_simd_packed_compare_unit (.core_clk(core_clk), .reset(reset),
        .issue_valid(issue_valid), .instr(instr), .src1_value(src1_value), .src2_value(src2_value),
        .src2_read(src2_read), .illegal(illegal), .result(result), .result_valid(result_valid));
    spc_operand_model i_spc_operand_model (.instr(instr), .src2_read(src2_read), .src1_value(src1_value),
        .src2_value(src2_value));
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    function automatic logic [31:0] expect_mask(input logic [4:0] f5, input logic [2:0] f3, input logic [31:0] a,
                                                input logic [31:0] b, input logic [5:0] imm);
        int w;
        logic [15:0] la, lb;
        logic signed [16:0] x, y;
        logic hit;
        logic [31:0] m;
        m = 32'h0;
        w = f3[0] ? 8 : 16;
        for (int i = 0; i < 32 / w; i++) begin
            la = 16'(a >> (i * w));
            lb = f3[1] ? {{10{imm[5]}}, imm} : 16'(b >> (f3[2] ? 0 : i * w));
            x = w == 8 ? 17'($signed(la[7:0])) : 17'($signed(la));
            y = w == 8 ? 17'($signed(lb[7:0])) : 17'($signed(lb));
            if (f5 > 5'h05) begin
                x = w == 8 ? 17'(la[7:0]) : 17'(la);
                y = w == 8 ? 17'(lb[7:0]) : 17'(lb);
            end
            case (f5)
                5'h00: hit = x == y;
                5'h01: hit = x != y;
                5'h02, 5'h06: hit = x > y;
                5'h03, 5'h07: hit = x >= y;
                5'h04, 5'h08: hit = x < y;
                default: hit = x <= y;
            endcase
            if (hit) m |= (w == 8 ? 32'hff : 32'hffff) << (i * w);
        end
        return m;
    endfunction : expect_mask
    task automatic issue(input logic [4:0] f5, input logic [2:0] f3, input logic [5:0] imm);
        issue_valid = 1'b1;
        instr = {f5, 1'b1, f3[1] ? {imm[0], imm[5:1]} : 6'h02, 5'h01, f3, 5'h03, SPC_MAJOR_OPCODE};
        #1;
        chk("src2_read", {31'h0, !f3[1]}, {31'h0, src2_read});
        chk("illegal", 32'h0, {31'h0, illegal});
        @(posedge core_clk);
        #1;
        chk("result_valid", 32'h1, {31'h0, result_valid});
        chk("result", expect_mask(f5, f3, i_spc_operand_model.regs[1], i_spc_operand_model.regs[2], imm), result);
    endtask : issue
    task automatic t_relations;
        for (int s = 0; s < 2; s++) begin
            i_spc_operand_model.regs[1] = s ? 32'h0001_fffe : 32'h807f_01ff;
            i_spc_operand_model.regs[2] = s ? 32'hfffe_0001 : 32'h7f80_01ff;
            for (int f = 0; f < 10; f++)
                foreach (forms[k]) issue(5'(f), forms[k], s ? 6'h01 : 6'h3f);
        end
        issue_valid = 1'b0;
    endtask : t_relations
    task automatic t_refused;
        logic [31:0] held;
        @(posedge core_clk);
        #1;
        chk("idle result_valid", 32'h0, {31'h0, result_valid});
        held = result;
        issue_valid = 1'b1;
        foreach (flips[k]) begin
            instr = 32'h0420_81fb ^ flips[k];
            #1;
            chk("illegal", 32'h1, {31'h0, illegal});
            @(posedge core_clk);
            #1;
            chk("refused valid", 32'h0, {31'h0, result_valid});
            chk("held result", held, result);
        end
        issue_valid = 1'b0;
    endtask : t_refused
    initial begin
        repeat (12) @(posedge core_clk);
        #1;
        reset = 1'b0;
        t_relations();
        t_refused();
        test_done();
    end
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule : spc_simd_packed_compare_unit_tb
`default_nettype wire

// ### src/spc_pkg.sv
`default_nettype none
package spc_pkg;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam logic [6:0] SPC_MAJOR_OPCODE = 7'h7b;
    localparam int         SPC_OPCODE_LSB   = 0;
    localparam int         SPC_FUNCT3_LSB   = 12;
    localparam int         SPC_RS1_LSB      = 15;
    localparam int         SPC_RS2_LSB      = 20;
    localparam int         SPC_IMM_LSB_POS  = 25;
    localparam int         SPC_FLAG_POS     = 26;
    localparam int         SPC_FUNCT5_LSB   = 27;
    localparam logic [4:0] SPC_FUNCT5_LAST  = 5'h09;

    // ------------------------------------------------------------
    // Variant codes of the function-3 field
    // ------------------------------------------------------------
    localparam logic [2:0] SPC_F3_HALF_VEC  = 3'h0;
    localparam logic [2:0] SPC_F3_HALF_SC   = 3'h4;
    localparam logic [2:0] SPC_F3_HALF_IMM  = 3'h6;
    localparam logic [2:0] SPC_F3_BYTE_VEC  = 3'h1;
    localparam logic [2:0] SPC_F3_BYTE_SC   = 3'h5;
    localparam logic [2:0] SPC_F3_BYTE_IMM  = 3'h7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] SPC_RESULT_RESET = 32'h0000_0000;

    // Relations, in function-5 order
    typedef enum logic [3:0] {
        SPC_REL_EQ, SPC_REL_NE, SPC_REL_GT, SPC_REL_GE, SPC_REL_LT,
        SPC_REL_LE, SPC_REL_GTU, SPC_REL_GEU, SPC_REL_LTU, SPC_REL_LEU
    } spc_rel_t;

    typedef enum logic [1:0] {
        SPC_FORM_VECTOR, SPC_FORM_SCALAR, SPC_FORM_IMMEDIATE
    } spc_form_t;

endpackage : spc_pkg
`default_nettype wire

// ### src/spc_simd_packed_compare_unit.sv
// Function
// - Byte lanes or half-word lanes by suffix
// - Lane holding test becomes all ones
// - Lane failing test becomes all zeros
// - Vector form compares lane with lane
// - Scalar form uses lowest second-source lane
// - Immediate form uses six-bit immediate only
// - Immediate reassembled from bits 24:20, 25
// - Equal test: lanes identical bit for bit
// - Not-equal test: any bit differs
// - Signed greater, greater-equal, less, less-equal
// - Unsigned greater, greater-equal, less, less-equal
// - Opcode 1111011, bit 26 set, funct5 0-9
// - Function-3 selects register or immediate variant
// - No flags, no status changes
`default_nettype none
module spc_simd_packed_compare_unit
    import spc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        issue_valid,
    input  wire logic [31:0] instr,
    input  wire logic [31:0] src1_value,
    input  wire logic [31:0] src2_value,
    output logic             src2_read,
    output logic             illegal,
    output logic [31:0]      result,
    output logic             result_valid
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] result;
        logic        result_valid;
    } spc_state_t;

    spc_state_t state;
    spc_state_t next_state;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One signed and one unsigned compare feed the eight ordered relations; EQ and NE use equality alone
    function automatic logic spc_relation(input spc_rel_t rel, input logic [15:0] a,
                                          input logic [15:0] b);
        logic s_lt;
        logic u_lt;
        s_lt = $signed(a) < $signed(b);
        u_lt = a < b;
        case (rel)
            SPC_REL_EQ:  spc_relation = (a == b);
            SPC_REL_NE:  spc_relation = (a != b);
            SPC_REL_GT:  spc_relation = !s_lt && (a != b);
            SPC_REL_GE:  spc_relation = !s_lt;
            SPC_REL_LT:  spc_relation = s_lt;
            SPC_REL_LE:  spc_relation = s_lt || (a == b);
            SPC_REL_GTU: spc_relation = !u_lt && (a != b);
            SPC_REL_GEU: spc_relation = !u_lt;
            SPC_REL_LTU: spc_relation = u_lt;
            SPC_REL_LEU: spc_relation = u_lt || (a == b);
            default:     spc_relation = 1'b0;
        endcase
    endfunction : spc_relation

    // Sign-extend a byte lane to 16 bits so one comparator serves both widths
    function automatic logic [15:0] spc_widen_byte(input logic [7:0] v);
        spc_widen_byte = {{8{v[7]}}, v};
    endfunction : spc_widen_byte

    // Comparand of one lane: own lane, lowest lane or immediate
    function automatic logic [15:0] spc_comparand(input spc_form_t f, input logic [15:0] own,
                                                   input logic [15:0] lowest, input logic [15:0] imm);
        case (f)
            SPC_FORM_VECTOR:    spc_comparand = own;
            SPC_FORM_SCALAR:    spc_comparand = lowest;
            SPC_FORM_IMMEDIATE: spc_comparand = imm;
            default:            spc_comparand = 16'h0000;
        endcase
    endfunction : spc_comparand

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [4:0]  funct5;
    logic [2:0]  funct3;
    logic [5:0]  six_bit_comparand;
    logic        byte_mode;
    logic        form_ok;
    logic        decode_ok;
    spc_form_t   form;
    spc_rel_t    rel;
    logic        opcode_ok;
    logic        funct5_ok;
    logic        bit25_ok;
    logic        taken;
    logic        rel_unsigned;

    assign funct5            = instr[SPC_FUNCT5_LSB +: 5];
    assign funct3            = instr[SPC_FUNCT3_LSB +: 3];
    assign six_bit_comparand = {instr[SPC_RS2_LSB +: 5], instr[SPC_IMM_LSB_POS]};
    assign rel               = spc_rel_t'(funct5[3:0]);

    // Lane width and operand source from function-3
    always_comb begin
        byte_mode = 1'b0;
        form      = SPC_FORM_VECTOR;
        form_ok   = 1'b1;
        case (funct3)
            SPC_F3_HALF_VEC: form = SPC_FORM_VECTOR;
            SPC_F3_HALF_SC:  form = SPC_FORM_SCALAR;
            SPC_F3_HALF_IMM: form = SPC_FORM_IMMEDIATE;
            SPC_F3_BYTE_VEC: begin
                byte_mode = 1'b1;
                form      = SPC_FORM_VECTOR;
            end
            SPC_F3_BYTE_SC: begin
                byte_mode = 1'b1;
                form      = SPC_FORM_SCALAR;
            end
            SPC_F3_BYTE_IMM: begin
                byte_mode = 1'b1;
                form      = SPC_FORM_IMMEDIATE;
            end
            default: form_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Encoding checks
    // ------------------------------------------------------------
    // Register-form encodings also need bit 25 clear
    assign opcode_ok    = (instr[SPC_OPCODE_LSB +: 7] == SPC_MAJOR_OPCODE) && instr[SPC_FLAG_POS];
    assign funct5_ok    = (funct5 <= SPC_FUNCT5_LAST);
    assign bit25_ok     = (form == SPC_FORM_IMMEDIATE) || !instr[SPC_IMM_LSB_POS];
    assign decode_ok    = opcode_ok && funct5_ok && form_ok && bit25_ok;
    assign taken        = issue_valid && decode_ok;
    assign rel_unsigned = (rel >= SPC_REL_GTU);

    // Refused encodings leave the result untouched
    assign illegal   = issue_valid && !decode_ok;
    assign src2_read = taken && (form != SPC_FORM_IMMEDIATE);

    // ------------------------------------------------------------
    // Lane compare
    // ------------------------------------------------------------
    logic [31:0] byte_lanes;
    logic [31:0] half_lanes;
    logic [31:0] lane_mask;
    logic [15:0] imm_ext;

    // Sign extension also serves unsigned forms, cut to lane width below
    assign imm_ext = {{10{six_bit_comparand[5]}}, six_bit_comparand};

    // Four byte lanes; unsigned relations must not see the sign extension
    always_comb begin
        logic [15:0] a;
        logic [15:0] b;
        a          = 16'h0000;
        b          = 16'h0000;
        byte_lanes = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            a = spc_widen_byte(src1_value[8*i +: 8]);
            b = spc_comparand(form, spc_widen_byte(src2_value[8*i +: 8]),
                              spc_widen_byte(src2_value[7:0]), imm_ext);
            if (rel_unsigned) begin
                a = {8'h00, a[7:0]};
                b = {8'h00, b[7:0]};
            end
            byte_lanes[8*i +: 8] = spc_relation(rel, a, b) ? 8'hff : 8'h00;
        end
    end

    // Two half-word lanes
    always_comb begin
        logic [15:0] b;
        b          = 16'h0000;
        half_lanes = 32'h0000_0000;
        for (int i = 0; i < 2; i++) begin
            b = spc_comparand(form, src2_value[16*i +: 16], src2_value[15:0], imm_ext);
            half_lanes[16*i +: 16] = spc_relation(rel, src1_value[16*i +: 16], b) ? 16'hffff : 16'h0000;
        end
    end

    assign lane_mask = byte_mode ? byte_lanes : half_lanes;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // No flag or status output exists; only the lane mask is produced
    always_comb begin
        next_state              = state;
        next_state.result_valid = taken;
        if (taken) begin
            next_state.result = lane_mask;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Result holds until the next accepted instruction
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= '{result: SPC_RESULT_RESET, result_valid: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign result       = state.result;
    assign result_valid = state.result_valid;

endmodule : spc_simd_packed_compare_unit
`default_nettype wire
